// *** src/dsac_consts.svh ***
`ifndef DSAC_CONSTS_SVH
`define DSAC_CONSTS_SVH
// ----------------------------------------
// Register indices (byte address = 4*index)
// ----------------------------------------
`define DSAC_IDX_GAIN     8'h01
`define DSAC_IDX_OFFS     8'h02
`define DSAC_IDX_CHSEL    8'h03
`define DSAC_IDX_RES_LO   8'h04
`define DSAC_IDX_RES_MID  8'h05
`define DSAC_IDX_RES_HI   8'h06
`define DSAC_IDX_MAIN     8'h07
`define DSAC_IDX_AUX      8'h08
`define DSAC_IDX_CLKDIV   8'h09
`define DSAC_IDX_STATUS   8'h0A
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DSAC_MAIN_RST_BIT   7
`define DSAC_MAIN_SLP_BIT   6
`define DSAC_MAIN_OFF_BIT   5
`define DSAC_AUX_HOLD_BIT   2
`define DSAC_AUX_EOC_BIT    1
// ----------------------------------------
// Reset values
// ----------------------------------------
`define DSAC_MAIN_RESET   8'h20
`define DSAC_ZERO8        8'h00
// ----------------------------------------
// Field codes and limits
// ----------------------------------------
`define DSAC_OSR_MAX_CODE 4'h8
`define DSAC_OSR_BASE     32'd32768
`define DSAC_DIV_N30_CODE 3'h0
`define DSAC_DIV_N12_CODE 3'h2
`define DSAC_DIV_N30      32'd30
`define DSAC_DIV_N12      32'd12
`define DSAC_MCLK_BYPASS  5'h1F
`define DSAC_RES_MAX      24'h7F_FFFF
`define DSAC_RES_MIN      24'h80_0000
`endif

// *** src/dsac_pkg.sv ***
`default_nettype none
package dsac_pkg;
  typedef enum logic [1:0] {DSAC_PWR_DOWN, DSAC_SLEEP, DSAC_NORMAL, DSAC_FRESET} dsac_mode_e;
  typedef logic [7:0] dsac_byte_t;
endpackage : dsac_pkg
`default_nettype wire

// *** src/dsac_conv_timer.sv ***
`include "dsac_consts.svh"
`default_nettype none
// ----------------------------------------
// Converter pacing: master clock enable, then N*OSR count
// ----------------------------------------
module dsac_conv_timer #(
  parameter int CW = 32
) (
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          run_in,
  input  wire logic          restart_in,
  input  wire logic [4:0]    mclk_div_in,
  input  wire logic [CW-1:0] period_in,
  output logic               done_out
);
  logic [5:0]    pre_r;
  logic [CW-1:0] cnt_r;
  logic          mclk_en;
  logic [5:0]    pre_lim;

  assign pre_lim = (mclk_div_in == `DSAC_MCLK_BYPASS) ? 6'h00 : 6'({mclk_div_in, 1'b0} + 6'h01);
  // A smaller divide code can leave the prescaler above the new limit
  assign mclk_en = (pre_r >= pre_lim);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_r <= 6'h00;
    end else if (restart_in || mclk_en) begin
      pre_r <= 6'h00;
    end else begin
      pre_r <= pre_r + 6'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r    <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (restart_in || !run_in) begin
        cnt_r <= '0;
      end else if (mclk_en) begin
        if (cnt_r >= period_in - CW'(1)) begin
          cnt_r    <= '0;
          done_out <= 1'b1;
        end else begin
          cnt_r <= cnt_r + CW'(1);
        end
      end
    end
  end
  a_bypass_rate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mclk_div_in == `DSAC_MCLK_BYPASS |-> mclk_en) else $error("bypassed master clock not every cycle");
  a_done_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    done_out |=> !done_out) else $error("completion longer than one cycle");
endmodule : dsac_conv_timer
`default_nettype wire

// *** src/dsac_top.sv ***
`include "dsac_consts.svh"
`default_nettype none
module dsac_top #(
  parameter int CW = 32
) (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic [31:0]      HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic [23:0] MOD_SAMPLE_IN,
  output logic [1:0]       REF_GAIN_OUT,
  output logic [1:0]       CONV_GAIN_OUT,
  output logic [6:0]       AMP_GAIN_OUT,
  output logic             INPUT_SHORT_OUT,
  output logic [1:0]       INPUT_ROUTE_OUT,
  output logic signed [2:0] OFFSET_QUARTERS_OUT,
  output logic [7:0]       NEG_ROUTE_OUT,
  output logic [7:0]       POS_ROUTE_OUT,
  output logic             REF_EXTERNAL_OUT,
  output logic             NEG_REF_BUFFER_EN_OUT,
  output logic             POS_REF_BUFFER_EN_OUT,
  output logic             BANDGAP_ON_OUT,
  output logic             AMP_ON_OUT,
  output logic             MODULATOR_ON_OUT,
  output logic             FILTER_RESET_OUT,
  output logic             CONFIG_ERROR_OUT
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  dsac_pkg::dsac_byte_t gain_r, offs_r, chsel_r, main_r, aux_r, clkdiv_r;
  logic [23:0]          result_r;
  logic [7:0]           ap_idx_r;
  logic                 ap_wr_r;
  logic                 ap_rd_r;
  logic [23:0]          mod_s1_r;
  logic [23:0]          mod_s2_r;
  logic [23:0]          mod_s3_r;
  logic [23:0]          mod_word_r;
  logic [31:0]          cfg_prev_r;
  logic                 restart_r;
  dsac_pkg::dsac_mode_e mode;
  logic                 conv_done;
  logic [CW-1:0]        period;
  logic [CW-1:0]        osr;
  logic [CW-1:0]        ndiv;
  logic                 cfg_bad;
  logic                 run;
  logic [31:0]          cfg_now;
  logic                 wr_aux;

  function automatic logic [7:0] onehot3(input logic [2:0] c);
    onehot3 = 8'h01 << c;
  endfunction : onehot3

  // ----------------------------------------
  // AHB-Lite slave: zero wait, always OKAY
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ap_idx_r <= 8'h00;
      ap_wr_r  <= 1'b0;
      ap_rd_r  <= 1'b0;
    end else if (HREADY_IN) begin
      ap_idx_r <= HADDR_IN[9:2];
      ap_wr_r  <= HSEL_IN && HTRANS_IN[1] && HWRITE_IN;
      ap_rd_r  <= HSEL_IN && HTRANS_IN[1] && !HWRITE_IN;
    end
  end
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;

  assign wr_aux = ap_wr_r && (ap_idx_r == `DSAC_IDX_AUX);

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      gain_r   <= `DSAC_ZERO8;
      offs_r   <= `DSAC_ZERO8;
      chsel_r  <= `DSAC_ZERO8;
      main_r   <= `DSAC_MAIN_RESET;
      clkdiv_r <= `DSAC_ZERO8;
    end else if (ap_wr_r) begin
      unique case (ap_idx_r)
        `DSAC_IDX_GAIN:   gain_r   <= {1'b0, HWDATA_IN[6:0]};
        `DSAC_IDX_OFFS:   offs_r   <= {1'b0, HWDATA_IN[6:1], 1'b0};
        `DSAC_IDX_CHSEL:  chsel_r  <= {2'b00, HWDATA_IN[5:0]};
        `DSAC_IDX_MAIN:   main_r   <= HWDATA_IN[7:0];
        `DSAC_IDX_CLKDIV: clkdiv_r <= {3'b000, HWDATA_IN[4:0]};
        default: ;
      endcase
    end
  end

  // Bit 0 is unimplemented and always reads zero
  // set wins over software clear
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      aux_r <= `DSAC_ZERO8;
    end else begin
      if (wr_aux) begin
        aux_r[7:2] <= HWDATA_IN[7:2];
      end
      if (conv_done && !aux_r[`DSAC_AUX_HOLD_BIT]) begin
        aux_r[`DSAC_AUX_EOC_BIT] <= 1'b1;
      end else if (wr_aux && !HWDATA_IN[`DSAC_AUX_EOC_BIT]) begin
        aux_r[`DSAC_AUX_EOC_BIT] <= 1'b0;
      end
      aux_r[0] <= 1'b0;
    end
  end

  // Read mux
  always_comb begin
    HRDATA_OUT = 32'h0000_0000;
    if (ap_rd_r) begin
      unique case (ap_idx_r)
        `DSAC_IDX_GAIN:    HRDATA_OUT[7:0] = gain_r;
        `DSAC_IDX_OFFS:    HRDATA_OUT[7:0] = offs_r;
        `DSAC_IDX_CHSEL:   HRDATA_OUT[7:0] = chsel_r;
        `DSAC_IDX_RES_LO:  HRDATA_OUT[7:0] = result_r[7:0];
        `DSAC_IDX_RES_MID: HRDATA_OUT[7:0] = result_r[15:8];
        `DSAC_IDX_RES_HI:  HRDATA_OUT[7:0] = result_r[23:16];
        `DSAC_IDX_MAIN:    HRDATA_OUT[7:0] = main_r;
        `DSAC_IDX_AUX:     HRDATA_OUT[7:0] = aux_r;
        `DSAC_IDX_CLKDIV:  HRDATA_OUT[7:0] = clkdiv_r;
        `DSAC_IDX_STATUS:  HRDATA_OUT[2:0] = {cfg_bad, 2'(mode)};
        default:           HRDATA_OUT = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Operating mode
  // ----------------------------------------
  // power-off dominates
  always_comb begin
    if (main_r[`DSAC_MAIN_OFF_BIT]) begin
      mode = dsac_pkg::DSAC_PWR_DOWN;
    end else if (main_r[`DSAC_MAIN_SLP_BIT]) begin
      mode = dsac_pkg::DSAC_SLEEP;
    end else if (main_r[`DSAC_MAIN_RST_BIT]) begin
      mode = dsac_pkg::DSAC_FRESET;
    end else begin
      mode = dsac_pkg::DSAC_NORMAL;
    end
  end

  assign BANDGAP_ON_OUT   = (mode != dsac_pkg::DSAC_PWR_DOWN);
  assign AMP_ON_OUT       = (mode != dsac_pkg::DSAC_PWR_DOWN);
  assign MODULATOR_ON_OUT = (mode == dsac_pkg::DSAC_NORMAL) || (mode == dsac_pkg::DSAC_FRESET);
  assign FILTER_RESET_OUT = (mode == dsac_pkg::DSAC_FRESET) || (mode == dsac_pkg::DSAC_PWR_DOWN);

  // ----------------------------------------
  // Analog steering decodes
  // ----------------------------------------
  // ref gain code
  assign REF_GAIN_OUT  = gain_r[6:5];
  assign CONV_GAIN_OUT = gain_r[4:3];
  // amp gain one-hot power of two
  assign AMP_GAIN_OUT  = (gain_r[2:0] == 3'h7) ? 7'h00 : 7'(onehot3(gain_r[2:0]));
  assign INPUT_SHORT_OUT = offs_r[6];
  assign INPUT_ROUTE_OUT = offs_r[5:4];
  assign OFFSET_QUARTERS_OUT = offs_r[3] ? -$signed({1'b0, offs_r[2:1]}) : $signed({1'b0, offs_r[2:1]});
  assign NEG_ROUTE_OUT = onehot3(chsel_r[5:3]) & 8'hF3;
  assign POS_ROUTE_OUT = onehot3(chsel_r[2:0]) & 8'hD3;
  assign REF_EXTERNAL_OUT = main_r[0];
  assign NEG_REF_BUFFER_EN_OUT = aux_r[4];
  assign POS_REF_BUFFER_EN_OUT = aux_r[3];

  // ----------------------------------------
  // Conversion pacing
  // ----------------------------------------
  // oversampling ratio
  assign osr = CW'(`DSAC_OSR_BASE >> main_r[4:1]);
  assign ndiv = (aux_r[7:5] == `DSAC_DIV_N12_CODE) ? CW'(`DSAC_DIV_N12) : CW'(`DSAC_DIV_N30);
  assign cfg_bad = (main_r[4:1] > `DSAC_OSR_MAX_CODE) ||
                   ((aux_r[7:5] != `DSAC_DIV_N30_CODE) && (aux_r[7:5] != `DSAC_DIV_N12_CODE));
  assign CONFIG_ERROR_OUT = cfg_bad;
  assign period = CW'(osr * ndiv);
  assign run    = (mode == dsac_pkg::DSAC_NORMAL) && !cfg_bad;

  // The restart lags a change by one cycle; the timer then counts from zero
  // gain, channel, ref, OSR, divider or clock change restarts accumulation; offset changes do not
  assign cfg_now = {gain_r, chsel_r, main_r[4:0], aux_r[7:5], clkdiv_r};
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cfg_prev_r <= 32'h0000_0000;
      restart_r  <= 1'b1;
    end else begin
      cfg_prev_r <= cfg_now;
      restart_r  <= (cfg_prev_r != cfg_now) || (mode != dsac_pkg::DSAC_NORMAL);
    end
  end

  dsac_conv_timer #(
    .CW (CW)
  ) u_timer (
    .clk_in      (SYS_CLK_IN),
    .rst_n_in    (RESET_N_IN),
    .run_in      (run),
    .restart_in  (restart_r),
    .mclk_div_in (clkdiv_r[4:0]),
    .period_in   (period),
    .done_out    (conv_done)
  );

  // ----------------------------------------
  // Result capture
  // ----------------------------------------
  // Modulator sample arrives from the analog side
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      mod_s1_r <= 24'h00_0000;
      mod_s2_r <= 24'h00_0000;
      mod_s3_r <= 24'h00_0000;
    end else begin
      mod_s1_r <= MOD_SAMPLE_IN;
      mod_s2_r <= mod_s1_r;
      mod_s3_r <= mod_s2_r;
    end
  end

  // The word crosses with no handshake: only a value seen twice in a row
  // is taken, so a capture never mixes bits of two samples
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      mod_word_r <= 24'h00_0000;
    end else if (mod_s3_r == mod_s2_r) begin
      mod_word_r <= mod_s3_r;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      result_r <= 24'h00_0000;
    end else if (conv_done && !aux_r[`DSAC_AUX_HOLD_BIT]) begin
      result_r <= mod_word_r;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_eoc_sets: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    conv_done && !aux_r[2] |=> aux_r[1]) else $error("eoc not set");
  a_eoc_frozen: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    aux_r[2] && !wr_aux |=> $stable(aux_r[1])) else $error("eoc moved while latched");
  a_hold_result: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    aux_r[2] |=> $stable(result_r)) else $error("result changed while latched");
  a_off_dominates: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    main_r[5] |-> !BANDGAP_ON_OUT && !MODULATOR_ON_OUT) else $error("power off ignored");
  a_sleep_amp: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    !main_r[5] && main_r[6] |-> AMP_ON_OUT && !MODULATOR_ON_OUT) else $error("sleep mode wrong");
  a_freset_nodone: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    main_r[7] ##1 main_r[7] |-> !conv_done) else $error("conversion during filter reset");
  a_amp_gain: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    gain_r[2:0] == 3'h6 |-> AMP_GAIN_OUT == 7'h40) else $error("amp gain 64 wrong");
  a_offset_zero: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    offs_r[2:1] == 2'b00 |-> OFFSET_QUARTERS_OUT == 3'sd0) else $error("offset not zero");
  a_period: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    main_r[4:1] == 4'h8 && aux_r[7:5] == 3'h2 |-> period == CW'(1536)) else $error("period wrong");
  a_eoc_kept: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    aux_r[1] && !(wr_aux && !HWDATA_IN[1]) |=> aux_r[1]) else $error("eoc cleared by hardware");
  a_restart_quiet: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    restart_r |=> !conv_done) else $error("completion during restart");
  a_result_done: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    !conv_done |=> $stable(result_r)) else $error("result changed without completion");
  a_osr_top: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    main_r[4:1] == 4'h0 |-> osr == CW'(`DSAC_OSR_BASE)) else $error("oversampling ratio wrong");
  a_bad_norun: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    cfg_bad |=> !conv_done) else $error("completion with reserved code");
  a_div_n30: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    aux_r[7:5] == 3'h0 |-> ndiv == CW'(`DSAC_DIV_N30)) else $error("divide thirty wrong");
  a_neg_cmode: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    chsel_r[5:3] == 3'h6 |-> NEG_ROUTE_OUT == 8'h40) else $error("negative common mode route wrong");
  a_neg_resv: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    chsel_r[5:4] == 2'b01 |-> NEG_ROUTE_OUT == 8'h00) else $error("negative reserved route open");
  a_pos_resv: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    chsel_r[2:0] == 3'h5 |-> POS_ROUTE_OUT == 8'h00) else $error("positive reserved route open");
  a_freset_out: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    mode == dsac_pkg::DSAC_FRESET |-> FILTER_RESET_OUT && MODULATOR_ON_OUT) else $error("filter reset mode wrong");
  a_normal_on: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    mode == dsac_pkg::DSAC_NORMAL |-> AMP_ON_OUT && MODULATOR_ON_OUT && !FILTER_RESET_OUT) else $error("normal mode wrong");
  a_sleep_filter: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    !main_r[5] && main_r[6] |-> BANDGAP_ON_OUT && !FILTER_RESET_OUT) else $error("sleep mode filter wrong");
  a_amp_resv: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    gain_r[2:0] == 3'h7 |-> AMP_GAIN_OUT == 7'h00) else $error("reserved amp gain not zero");
  a_offset_neg: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    offs_r[3:1] == 3'h7 |-> OFFSET_QUARTERS_OUT == -3'sd3) else $error("offset minus three wrong");
  a_down_idle: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    mode == dsac_pkg::DSAC_PWR_DOWN |=> !conv_done) else $error("completion while powered off");
endmodule : dsac_top
`default_nettype wire

// *** sim/dsac_mod_model.sv ***
`default_nettype none
// ----------------------------------------
// Modulator and filter stand-in
// ----------------------------------------
module dsac_mod_model (
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               mod_on_in,
  input  wire logic               filt_rst_in,
  input  wire logic signed [24:0] level_in,
  output logic [23:0]             sample_out
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sample_out <= 24'h00_0000;
    end else if (!mod_on_in || filt_rst_in) begin
      // A stopped filter toggles its output, so it never shows a steady value
      sample_out <= ~sample_out;
    end else if (level_in > $signed(25'h07F_FFFF)) begin
      sample_out <= 24'h7F_FFFF;
    end else if (level_in < $signed(25'h180_0000)) begin
      sample_out <= 24'h80_0000;
    end else begin
      sample_out <= level_in[23:0];
    end
  end
endmodule : dsac_mod_model
`default_nettype wire

// *** sim/tb_top.sv ***
`include "dsac_consts.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define TB_CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
  typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd; int sel; logic [7:0] oe;} dsac_row_s;
  // Bypassed master clock, N=12, OSR code 8
  localparam int P = `DSAC_DIV_N12 * (`DSAC_OSR_BASE >> `DSAC_OSR_MAX_CODE);
  localparam int NR = 33;
  logic               clk, rst_n, hsel, hwrite, hready, rdy, hresp;
  logic [1:0]         htrans, ref_g, conv_g, route;
  logic [2:0]         hsize;
  logic [31:0]        haddr, hwdata, hrdata;
  logic [23:0]        sample;
  logic [6:0]         amp_g;
  logic signed [2:0]  offs;
  logic [7:0]         neg_r, pos_r, v;
  logic               shrt, ref_ext, nbuf, pbuf, bg_on, amp_on, mod_on, f_rst, cfg_err;
  logic signed [24:0] level;
  int                 mismatches, check_count, cyc, t0, t1;
  logic [7:0]         stop [3] = '{8'h90, 8'h50, 8'hF0};
  dsac_row_s rows [NR] = '{
    '{8'h01, 8'h00, 8'h00, 0, 8'h01},
    '{8'h01, 8'h06, 8'h06, 0, 8'h40},
    '{8'h01, 8'h07, 8'h07, 0, 8'h00},
    '{8'h01, 8'h4B, 8'h4B, 1, 8'h09},
    '{8'h01, 8'hFF, 8'h7F, 1, 8'h0F},
    '{8'h02, 8'hFF, 8'h7E, 2, 8'h3D},
    '{8'h02, 8'h08, 8'h08, 2, 8'h00},
    '{8'h02, 8'h06, 8'h06, 2, 8'h03},
    '{8'h02, 8'h0A, 8'h0A, 2, 8'h07},
    '{8'h03, 8'h37, 8'h37, 3, 8'h40},
    '{8'h03, 8'h37, 8'h37, 4, 8'h80},
    '{8'h03, 8'h25, 8'h25, 3, 8'h10},
    '{8'h03, 8'h25, 8'h25, 4, 8'h00},
    '{8'h03, 8'h2C, 8'h2C, 3, 8'h20},
    '{8'h03, 8'h2C, 8'h2C, 4, 8'h10},
    '{8'h03, 8'h12, 8'h12, 3, 8'h00},
    '{8'h03, 8'h1B, 8'h1B, 4, 8'h00},
    '{8'h07, 8'h21, 8'h21, 5, 8'h04},
    '{8'h08, 8'h18, 8'h18, 5, 8'h07},
    '{8'h07, 8'h20, 8'h20, 5, 8'h03},
    '{8'h08, 8'h10, 8'h10, 5, 8'h02},
    '{8'h08, 8'h20, 8'h20, 6, 8'h01},
    '{8'h08, 8'h40, 8'h40, 6, 8'h00},
    '{8'h08, 8'h00, 8'h00, 6, 8'h00},
    '{8'h07, 8'h32, 8'h32, 6, 8'h01},
    '{8'h07, 8'h30, 8'h30, 6, 8'h00},
    '{8'h07, 8'hE0, 8'hE0, 7, 8'h01},
    '{8'h07, 8'h40, 8'h40, 7, 8'h0C},
    '{8'h07, 8'h80, 8'h80, 7, 8'h0F},
    '{8'h07, 8'h00, 8'h00, 7, 8'h0E},
    '{8'h08, 8'h02, 8'h00, 8, 8'h00},
    '{8'h09, 8'hFF, 8'h1F, 8, 8'h00},
    '{8'h30, 8'hFF, 8'h00, 8, 8'h00}
  };
  assign hready = rdy;
  dsac_top i_dut (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(rdy), .HRESP_OUT(hresp),
    .MOD_SAMPLE_IN(sample), .REF_GAIN_OUT(ref_g), .CONV_GAIN_OUT(conv_g), .AMP_GAIN_OUT(amp_g),
    .INPUT_SHORT_OUT(shrt), .INPUT_ROUTE_OUT(route), .OFFSET_QUARTERS_OUT(offs),
    .NEG_ROUTE_OUT(neg_r), .POS_ROUTE_OUT(pos_r), .REF_EXTERNAL_OUT(ref_ext),
    .NEG_REF_BUFFER_EN_OUT(nbuf), .POS_REF_BUFFER_EN_OUT(pbuf), .BANDGAP_ON_OUT(bg_on),
    .AMP_ON_OUT(amp_on), .MODULATOR_ON_OUT(mod_on), .FILTER_RESET_OUT(f_rst),
    .CONFIG_ERROR_OUT(cfg_err));
  dsac_mod_model i_mod (.clk_in(clk), .rst_n_in(rst_n), .mod_on_in(mod_on),
    .filt_rst_in(f_rst), .level_in(level), .sample_out(sample));
  // ----------------------------------------
  // Bus master and helpers
  // ----------------------------------------
  task automatic ahb_xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {22'h00_0000, idx, 2'b00};
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    q = hrdata[7:0];
  endtask : ahb_xfer
  task automatic ahb_wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    ahb_xfer(1'b1, idx, d, q);
  endtask : ahb_wr
  task automatic ahb_rd(input logic [7:0] idx, output logic [7:0] q);
    ahb_xfer(1'b0, idx, 8'h00, q);
  endtask : ahb_rd
  task automatic wait_eoc(output int t);
    int k;
    logic [7:0] q;
    k = 0;
    q = 8'h00;
    while (q[1] !== 1'b1 && k < 3000) begin
      ahb_rd(`DSAC_IDX_AUX, q);
      k++;
    end
    t = cyc;
    if (k >= 3000) `TB_CHK("eoc wait", 1'b1, 1'b0)
  endtask : wait_eoc
  function automatic logic [7:0] get_out(input int s);
    case (s)
      0: get_out = {1'b0, amp_g};
      1: get_out = {4'h0, ref_g, conv_g};
      2: get_out = {2'b00, shrt, route, offs};
      3: get_out = neg_r;
      4: get_out = pos_r;
      5: get_out = {5'h00, ref_ext, nbuf, pbuf};
      6: get_out = {7'h00, cfg_err};
      7: get_out = {4'h0, bg_on, amp_on, mod_on, f_rst};
      default: get_out = 8'h00;
    endcase
  endfunction : get_out
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    finish_test();
  end
  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    level = 25'h012_3456;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ahb_rd(`DSAC_IDX_MAIN, v);
    `TB_CHK("main reset", `DSAC_MAIN_RESET, v)
    `TB_CHK("power reset", 8'h01, get_out(7))
    for (int i = 0; i < NR; i++) begin
      ahb_wr(rows[i].idx, rows[i].wd);
      ahb_rd(rows[i].idx, v);
      `TB_CHK("row read", rows[i].rd, v)
      `TB_CHK("bus response", 1'b0, hresp)
      `TB_CHK("row out", rows[i].oe, get_out(rows[i].sel))
    end
    ahb_wr(`DSAC_IDX_AUX, 8'h40);
    ahb_wr(`DSAC_IDX_MAIN, 8'h10);
    ahb_wr(`DSAC_IDX_CHSEL, 8'h30);
    ahb_wr(`DSAC_IDX_MAIN, 8'h90);
    ahb_wr(`DSAC_IDX_MAIN, 8'h10);
    wait_eoc(t0);
    ahb_wr(`DSAC_IDX_AUX, 8'h40);
    repeat (P - 24) @(posedge clk);
    ahb_rd(`DSAC_IDX_AUX, v);
    `TB_CHK("eoc early", 8'h40, v)
    wait_eoc(t1);
    `TB_CHK("period", 1'b1, (t1 - t0 >= P - 4) && (t1 - t0 <= P + 4))
    ahb_rd(`DSAC_IDX_RES_MID, v);
    `TB_CHK("result mid", 8'h34, v)
    // Hold freezes result and flag while conversions go on
    ahb_wr(`DSAC_IDX_AUX, 8'h44);
    level <= 25'h17F_FFFE;
    repeat (2 * P) @(posedge clk);
    ahb_rd(`DSAC_IDX_AUX, v);
    `TB_CHK("eoc held", 8'h44, v)
    ahb_rd(`DSAC_IDX_RES_HI, v);
    `TB_CHK("result held", 8'h12, v)
    ahb_wr(`DSAC_IDX_AUX, 8'h40);
    wait_eoc(t0);
    ahb_rd(`DSAC_IDX_RES_HI, v);
    `TB_CHK("result min", 8'h80, v)
    repeat (P) @(posedge clk);
    ahb_rd(`DSAC_IDX_AUX, v);
    `TB_CHK("eoc stays", 8'h42, v)
    // power off last, as before host idle
    for (int i = 0; i < 3; i++) begin
      ahb_wr(`DSAC_IDX_MAIN, stop[i]);
      ahb_wr(`DSAC_IDX_AUX, 8'h40);
      repeat (2 * P) @(posedge clk);
      ahb_rd(`DSAC_IDX_AUX, v);
      `TB_CHK("eoc stopped", 8'h40, v)
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ahb_rd(`DSAC_IDX_MAIN, v);
    `TB_CHK("main rereset", `DSAC_MAIN_RESET, v)
    `TB_CHK("power rereset", 8'h01, get_out(7))
    ahb_rd(`DSAC_IDX_AUX, v);
    `TB_CHK("aux rereset", `DSAC_ZERO8, v)
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
